//--- core/adcc_top.sv
// converter control and result registers of the 8-bit successive approximation converter
// Functional notes
// - bit 7 gates the end-of-conversion interrupt
// - done bit sets on completion, result valid
// - writing the go bit clears done
// - done bit is the interrupt pending flag
// - go bit 5 starts a conversion
// - go during conversion restarts it fresh
// - go bit always reads zero
// - bit 4 powers converter, zero idles it
// - control register at D1h, bits 3-0 unused
// - result register at D0h, read only
// - code is input over supply span/256
// - sync option defers start until wait entered
// - steps advance on oscillator divided by twelve
// - reset aborts, control becomes 40h, masked
// - interrupt vector 4 raised when done sets
module adcc_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] bus_addr, // data-space address
  input wire logic bus_wr, // one-cycle write strobe
  input wire logic bus_rd, // one-cycle read strobe
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata, // registered read data
  input wire logic sync_start_opt, // synchronized-start option strap
  input wire logic core_in_wait, // core has effectively entered wait
  input wire logic cmp_hi, // analog comparator: input above trial level
  output logic [7:0] dac_trial, // trial code driven to the comparator ladder
  output logic conv_active, // converter sampling and stepping
  output logic analog_power_on, // converter analog power enable
  output logic irq_vec4_req // request on interrupt vector 4
);
  // ------------------------------
  // overview
  // ------------------------------
  // a go write clears done and launches; a strobe every twelve clocks steps the search
  // eight steps resolve the code msb first, then done and the result load on one edge
  // the sync option parks a launch in an armed state until the core has gone to sleep
  // limitation: there is no sample and hold, so the input must stay still for the run
  // trade-off: the request is registered, one clock late, so every output is a flop
  // ------------------------------
  // register state
  // ------------------------------
  logic irq_en_q; // irq_enable_bit
  logic done_q; // end of conversion
  logic pwr_q; // converter_power_on
  logic [7:0] result_q; // conversion_result
  logic [7:0] rdata_q;
  logic irq_q;
  logic active_q;
  logic [7:0] trial_q;
  adcc_pkg::adcc_state_e state_q;
  adcc_pkg::adcc_state_e state_d;
  // strobes and sub-block wires
  logic wr_ctrl;
  logic go_wr;
  logic launch;
  logic tick;
  logic [7:0] sar_trial;
  logic sar_last;
  logic finish;

  // bus decode; the go position matters only on a control write
  assign wr_ctrl = bus_wr && bus_addr == adcc_pkg::ADDR_CONTROL;
  assign go_wr = wr_ctrl && bus_wdata[adcc_pkg::BIT_GO];
  // ------------------------------
  // conversion sequencer
  // ------------------------------
  // a go write wins over the state transitions unless power is cleared, so a running conversion is dropped and relaunched or armed
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      adcc_pkg::ADCC_IDLE:
        state_d = state_q;
      adcc_pkg::ADCC_ARMED:
        if (core_in_wait)
          state_d = adcc_pkg::ADCC_CONV;
      adcc_pkg::ADCC_CONV:
        if (sar_last)
          state_d = adcc_pkg::ADCC_IDLE;
      default:
        state_d = adcc_pkg::ADCC_IDLE;
    endcase
    if (go_wr)
    begin
      if (sync_start_opt && !core_in_wait)
        state_d = adcc_pkg::ADCC_ARMED;
      else
        state_d = adcc_pkg::ADCC_CONV;
    end
    // the written power bit rules in the cycle of its own write, so a go
    // that comes with power cleared is refused rather than launched
    if (wr_ctrl ? !bus_wdata[adcc_pkg::BIT_PWR] : !pwr_q)
      state_d = adcc_pkg::ADCC_IDLE;
  end

  // launch realigns divider and loads midscale trial
  assign launch = state_d == adcc_pkg::ADCC_CONV && (state_q != adcc_pkg::ADCC_CONV || go_wr);
  assign finish = state_q == adcc_pkg::ADCC_CONV && sar_last && !go_wr && pwr_q;

  // sequencer state; reset aborts any conversion
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= adcc_pkg::ADCC_IDLE;
    else
      state_q <= state_d;
  end

  // step strobe from oscillator divided by twelve
  adcc_tick u_tick (
    .clk(clk),
    .rst_b(rst_b),
    .restart(launch),
    .tick(tick)
  );

  // trial code search, one bit per conversion clock
  adcc_sar u_sar (
    .clk(clk),
    .rst_b(rst_b),
    .start(launch),
    .step(tick && state_q == adcc_pkg::ADCC_CONV),
    .cmp_hi(cmp_hi),
    .trial(sar_trial),
    .last(sar_last)
  );

  // ------------------------------
  // control register fields
  // ------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_en_q <= adcc_pkg::CTRL_RESET[adcc_pkg::BIT_IRQ_EN];
      pwr_q <= adcc_pkg::CTRL_RESET[adcc_pkg::BIT_PWR];
    end
    else if (wr_ctrl)
    begin
      irq_en_q <= bus_wdata[adcc_pkg::BIT_IRQ_EN];
      pwr_q <= bus_wdata[adcc_pkg::BIT_PWR];
    end
  end

  // done flag: any write of the go position clears it; completion sets it
  // a go write also aborts the conversion, so the two never collide
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      done_q <= adcc_pkg::CTRL_RESET[adcc_pkg::BIT_DONE];
    else if (finish)
      done_q <= 1'b1;
    else if (go_wr)
      done_q <= 1'b0;
  end

  // result captured with the final trial bit resolved
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      result_q <= 8'h00;
    else if (finish)
      result_q <= cmp_hi ? sar_trial : (sar_trial & ~8'h01);
  end

  // ------------------------------
  // registered outputs
  // ------------------------------
  // interrupt request is level; pending stays while done and enable are high
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      irq_q <= 1'b0;
    else
      irq_q <= irq_en_q && done_q;
  end

  // analog side controls
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      active_q <= 1'b0;
      trial_q <= 8'h00;
    end
    else
    begin
      active_q <= state_d == adcc_pkg::ADCC_CONV;
      trial_q <= sar_trial;
    end
  end

  // read port; unused bits and go bit read as zero, unmapped reads zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_q <= 8'h00;
    else if (bus_rd && bus_addr == adcc_pkg::ADDR_CONTROL)
      rdata_q <= {irq_en_q, done_q, 1'b0, pwr_q, 4'h0};
    else if (bus_rd && bus_addr == adcc_pkg::ADDR_RESULT)
      rdata_q <= result_q;
    else
      rdata_q <= 8'h00;
  end

  // each output below is a flop; the assigns only rename
  assign bus_rdata = rdata_q;
  assign irq_vec4_req = irq_q;
  assign conv_active = active_q;
  assign dac_trial = trial_q;
  assign analog_power_on = pwr_q;

  // ------------------------------
  // conversion length monitor
  // ------------------------------
  // launch edge to capture edge spans eight steps of twelve clocks
  localparam int CONV_CYCLES = adcc_pkg::CLK_DIV * adcc_pkg::RES_BITS;
  localparam logic [6:0] CONV_LAST = 7'(CONV_CYCLES - 1);
  // helper count for the length check only; nothing in the datapath reads it
  logic [6:0] conv_cyc_q;

  // cleared on every launch, counts while converting, saturates instead of wrapping
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      conv_cyc_q <= 7'h00;
    else if (launch)
      conv_cyc_q <= 7'h00; // a restart times afresh
    else if (state_q == adcc_pkg::ADCC_CONV && !(&conv_cyc_q))
      conv_cyc_q <= conv_cyc_q + 7'h01;
  end

  // ------------------------------
  // checks
  // ------------------------------
  // request line is enable and done, one clock late
  irq_follows_done_a: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 irq_vec4_req == ($past(irq_en_q) && $past(done_q)))
    else $error("irq mismatch");
  // a cleared enable blocks the request
  irq_masked_a: assert property (@(posedge clk) disable iff (!rst_b)
    !irq_en_q ##1 !irq_en_q |-> !irq_vec4_req)
    else $error("masked irq raised");
  // done rising with enable set raises the vector four request next clock
  irq_on_done_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(done_q) && irq_en_q |=> irq_vec4_req)
    else $error("no irq on done");
  // any go write clears done
  go_clears_done_a: assert property (@(posedge clk) disable iff (!rst_b)
    go_wr |=> !done_q)
    else $error("done not cleared");
  // go position and unused bits always read zero
  go_reads_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    bus_rd && bus_addr == adcc_pkg::ADDR_CONTROL |=>
      bus_rdata[adcc_pkg::BIT_GO] == 1'b0 && bus_rdata[3:0] == 4'h0)
    else $error("go or unused bits read nonzero");
  // done bit reads back as held at the read edge
  done_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    bus_rd && bus_addr == adcc_pkg::ADDR_CONTROL |=>
      bus_rdata[adcc_pkg::BIT_DONE] == $past(done_q))
    else $error("done bit read wrong");
  // outside a read the bus shows zero
  rdata_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
    !bus_rd |=> bus_rdata == 8'h00)
    else $error("read data outside a read");
  // completion sets done and loads the trial with its last bit resolved
  finish_sets_done_a: assert property (@(posedge clk) disable iff (!rst_b)
    finish |=> done_q && result_q == {dac_trial[7:1], $past(cmp_hi)})
    else $error("done not set");
  // writes to the result address change nothing
  result_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    bus_wr && bus_addr == adcc_pkg::ADDR_RESULT && !finish |=> $stable(result_q))
    else $error("result written");
  // an unsynchronized go with power launches at once
  go_starts_conv_a: assert property (@(posedge clk) disable iff (!rst_b)
    go_wr && !sync_start_opt && bus_wdata[adcc_pkg::BIT_PWR] |=>
      state_q == adcc_pkg::ADCC_CONV)
    else $error("no start");
  // a go that clears power in the same write is refused
  go_off_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
    go_wr && !bus_wdata[adcc_pkg::BIT_PWR] |=> state_q == adcc_pkg::ADCC_IDLE)
    else $error("go launched without power");
  // armed waits for the core to sleep
  sync_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == adcc_pkg::ADCC_ARMED && !core_in_wait && !go_wr |=>
      state_q != adcc_pkg::ADCC_CONV)
    else $error("sync start too early");
  // eight quiet clocks after launch the conversion still runs
  conv_length_a: assert property (@(posedge clk) disable iff (!rst_b)
    launch && !sync_start_opt ##1 (!bus_wr && pwr_q) [*8] |-> state_q == adcc_pkg::ADCC_CONV)
    else $error("conversion ended too soon");
  // capture lands exactly eight steps of twelve clocks after launch
  conv_cycles_a: assert property (@(posedge clk) disable iff (!rst_b)
    finish |-> conv_cyc_q == CONV_LAST)
    else $error("conversion length wrong");
  // powered down sits idle
  power_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
    !pwr_q && !bus_wr |=> state_q == adcc_pkg::ADCC_IDLE)
    else $error("runs while powered down");
  // powered down shows no activity to the analog side
  off_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
    !pwr_q && !bus_wr |=> !conv_active)
    else $error("active while powered down");
endmodule // adcc_top

//--- core/adcc_pkg.sv
// constants shared by the converter control block
package adcc_pkg;
  localparam logic [7:0] ADDR_RESULT = 8'hD0; // conversion_result, read only
  localparam logic [7:0] ADDR_CONTROL = 8'hD1; // converter_control
  localparam logic [7:0] CTRL_RESET = 8'h40; // control value after reset
  localparam int BIT_IRQ_EN = 7; // irq_enable_bit
  localparam int BIT_DONE = 6; // end of conversion
  localparam int BIT_GO = 5; // conversion_go, write only
  localparam int BIT_PWR = 4; // converter_power_on
  localparam int CLK_DIV = 12; // conversion clock divider
  localparam logic [3:0] DIV_LAST = 4'(CLK_DIV - 1);
  localparam int RES_BITS = 8; // result width
  localparam logic [2:0] STEP_LAST = 3'h7; // index of the last trial bit
  typedef enum logic [1:0] {ADCC_IDLE, ADCC_ARMED, ADCC_CONV} adcc_state_e;
endpackage

//--- core/adcc_tick.sv
// divide-by-twelve strobe generator for the conversion clock
module adcc_tick (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic restart,
  output logic tick
);
  logic [3:0] cnt_q;
  // ------------------------------
  // divider counter
  // ------------------------------
  // restart realigns the phase so every conversion has equal step length
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_q <= 4'h0;
    else if (restart || cnt_q == adcc_pkg::DIV_LAST)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_q + 4'h1;
  end
  assign tick = !restart && cnt_q == adcc_pkg::DIV_LAST;
endmodule // adcc_tick

//--- core/adcc_sar.sv
// successive approximation register: one trial bit per step
module adcc_sar (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic step,
  input wire logic cmp_hi,
  output logic [7:0] trial,
  output logic last
);
  logic [7:0] sar_q;
  logic [2:0] idx_q;
  // ------------------------------
  // trial register
  // ------------------------------
  // start sets the midscale trial; each step keeps or drops the bit under test
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sar_q <= 8'h00;
      idx_q <= 3'h0;
    end
    else if (start)
    begin
      sar_q <= 8'h80;
      idx_q <= 3'h0;
    end
    else if (step)
    begin
      // cmp_hi means input is above trial, keep the bit
      if (!cmp_hi)
        sar_q[3'h7 - idx_q] <= 1'b0;
      if (idx_q != adcc_pkg::STEP_LAST)
        sar_q[3'h6 - idx_q] <= 1'b1;
      idx_q <= idx_q + 3'h1;
    end
  end
  assign trial = sar_q;
  assign last = step && idx_q == adcc_pkg::STEP_LAST;
endmodule // adcc_sar

//--- verification/adcc_top_tb_top.sv
// self-checking bench for the converter control block
module adcc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, bus_wr, bus_rd, sync_start_opt, core_in_wait, cmp_hi;
  logic [7:0] bus_addr, bus_wdata, bus_rdata, dac_trial;
  logic conv_active, analog_power_on, irq_vec4_req;
  int n_fail, compares, seed, n; // n: cycles of the last conversion
  logic [7:0] ain, rd_v; // modelled input code, last byte read
  logic m_en; // model of the enable bit
  logic [7:0] m_res[$]; // model: code of each completed conversion, newest last

  adcc_top u_dut (.clk(clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .sync_start_opt(sync_start_opt), .core_in_wait(core_in_wait), .cmp_hi(cmp_hi),
    .dac_trial(dac_trial), .conv_active(conv_active), .analog_power_on(analog_power_on),
    .irq_vec4_req(irq_vec4_req));

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // comparator: input sits half a step above its code, so ties never flip a trial
  always @(negedge clk)
    cmp_hi = (ain >= dac_trial);

  // --------------------------------------------------------------
  // checking and bus tasks
  // --------------------------------------------------------------
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chkn(string nm, int lo, int hi, int got);
    compares++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge clk);
    bus_wr = 1'b0;
  endtask

  // read data is valid in the cycle after the taking edge
  task automatic rd(logic [7:0] a);
    @(negedge clk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge clk);
    bus_rd = 1'b0;
    rd_v = bus_rdata;
  endtask

  // count cycles until the converter goes quiet; bounded so a hang ends
  task automatic run_out();
    repeat (2) @(negedge clk);
    n = 2;
    while (conv_active !== 1'b0 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    chkn("conversion cycles", 92, 102, n);
    m_res.push_back(ain);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog: the tests need about 700 cycles
  initial
  begin
    #(5 * 6000);
    n_fail++;
    wrap_up();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    seed = 71;
    n_fail = 0;
    compares = 0;
    rst_b = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
    sync_start_opt = 1'b0;
    core_in_wait = 1'b0;
    ain = 8'h00;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    rd(8'hD1);
    chk("control after reset", 8'h40, rd_v);
    // boundary codes first, then random; enable alternates
    for (int i = 0; i < 4; i++)
    begin
      ain = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      m_en = (i % 2 == 0);
      wr(8'hD1, {m_en, 7'h7F});
      rd(8'hD1);
      chk("control in flight", {m_en, 7'h10}, rd_v);
      chk("power", 8'h01, {7'h00, analog_power_on});
      run_out();
      rd(8'hD1);
      chk("control done", {m_en, 7'h50}, rd_v);
      rd(8'hD0);
      chk("result", m_res[$], rd_v);
      chk("irq", {7'h00, m_en}, {7'h00, irq_vec4_req});
    end
    // enabling later lets the pending done through
    wr(8'hD1, 8'h90);
    rd(8'hD1);
    chk("irq late enable", 8'h01, {7'h00, irq_vec4_req});
    // a second go mid-run starts afresh on the new input
    ain = 8'h5A;
    wr(8'hD1, 8'hB0);
    repeat (40) @(negedge clk);
    ain = 8'hA5;
    wr(8'hD1, 8'hB0);
    @(negedge clk);
    chk("fresh midscale", 8'h80, dac_trial);
    run_out();
    rd(8'hD0);
    chk("restart result", m_res[$], rd_v);
    wr(8'hD0, 8'h00);
    rd(8'hD0);
    chk("result write ignored", m_res[$], rd_v);
    rd(8'hD2);
    chk("unmapped read", 8'h00, rd_v);
    // go with power off stays idle
    wr(8'hD1, 8'h20);
    chk("off go ignored", 8'h00, {7'h00, conv_active});
    rd(8'hD1);
    chk("go clears done", 8'h00, rd_v);
    repeat (3) @(negedge clk);
    chk("powered down", 8'h00, {6'h00, analog_power_on, conv_active});
    // synchronized start waits for the core to sleep
    sync_start_opt = 1'b1;
    ain = 8'($random(seed));
    wr(8'hD1, 8'hB0);
    // the wait instruction comes four clocks after the start write
    repeat (4) @(negedge clk);
    chk("armed not running", 8'h00, {7'h00, conv_active});
    core_in_wait = 1'b1;
    run_out();
    // the core leaves wait on the end-of-conversion request
    @(negedge clk);
    chk("wake request", 8'h01, {7'h00, irq_vec4_req});
    core_in_wait = 1'b0;
    rd(8'hD0);
    chk("sync result", m_res[$], rd_v);
    // reset in mid conversion
    sync_start_opt = 1'b0;
    wr(8'hD1, 8'hB0);
    repeat (20) @(negedge clk);
    chk("running before reset", 8'h01, {7'h00, conv_active});
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    chk("reset quiet", 8'h00, {6'h00, conv_active, irq_vec4_req});
    rd(8'hD1);
    chk("control after reset", 8'h40, rd_v);
    wrap_up();
  end
endmodule // adcc_top_tb_top
